// ### sim/i2c_master_rx_ack_stop_arbitration_bench.sv
// self-checking bench for the master
`timescale 1ns/1ps
`default_nettype none
module i2c_master_rx_ack_stop_arbitration_bench;
    import tms_pkg::*;
    logic       ref_clk_i, reset_i, en, av, wr, rd, ce, cc, cl, rival, ld;
    logic       so, soe, dso, doe, ovf, pull, scl_w, sda_w;
    logic [7:0] rl, wd, sb, d;
    logic [8:0] pat;
    tms_go_t    gs, go;
    tms_stat_t  st;
    int         n_mismatch = 0, checks = 0, i, k;
    // open-drain wires with pull-ups
    assign scl_w = ~soe;
    assign sda_w = ~(doe | pull | rival);
    tms_master dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .enable_i(en),
        .rate_reload_reg_i(rl), .go_set_i(gs), .ack_value_bit_i(av), .buf_wr_i(wr),
        .buf_wdata_i(wd), .buf_rd_i(rd), .clr_event_i(ce), .clr_clash_i(cc),
        .clr_collision_i(cl), .scl_i(scl_w), .sda_i(sda_w), .scl_o(so), .scl_oe_o(soe),
        .sda_o(dso), .sda_oe_o(doe), .go_o(go), .stat_o(st), .shift_buffer_reg_o(sb),
        .rx_overflow_o(ovf));
    tms_slave sl_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .scl_i(scl_w), .ld_i(ld),
        .pat_i(pat), .pull_o(pull));
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    function automatic logic [8:0] frame(logic [7:0] b, logic a);
        return {b, a}; // slave bits then its ack slot
    endfunction
    task chk(string n, logic [7:0] s, logic [7:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task tk(int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task pulse(logic [4:0] m); // go bits, write, read
        @(posedge ref_clk_i);
        gs <= tms_go_t'(m[0] ? 4'h0 : m[4:1]);
        wr <= m[0] & ~m[1];
        rd <= m[0] & m[1];
        @(posedge ref_clk_i);
        {gs, wr, rd} <= '0;
    endtask
    task clr(logic [2:0] m); // event, clash, collision
        @(posedge ref_clk_i);
        {ce, cc, cl} <= m;
        @(posedge ref_clk_i);
        {ce, cc, cl} <= 3'b000;
        tk(3);
    endtask
    task ldp(logic [8:0] p);
        @(posedge ref_clk_i);
        ld <= 1'b1;
        pat <= p;
        @(posedge ref_clk_i);
        ld <= 1'b0;
    endtask
    task ev;
        for (k = 0; st.serial_event_flag !== 1'b1 && k < 9000; k++)
            tk(1);
        chk("event", st.serial_event_flag, 1'b1);
        clr(3'b100);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // read, refusals, collisions
    initial begin
        {av, wr, rd, ce, cc, cl, rival, ld, gs, wd} = '0;
        en = 1'b1;
        pat = '1;
        reset_i = 1'b1;
        void'($urandom(32'hdb48194d));
        rl = 8'h03 + 8'($urandom % 4);
        tk(3);
        reset_i <= 1'b0;
        tk(2);
        chk("stat", st, '0);
        pulse(5'b10000);
        ev;
        ldp(frame(8'hff, 1'($urandom)));
        wd <= {7'($urandom), 1'b1};
        pulse(5'b00001);
        ev;
        chk("ack_received_flag", st.ack_received_flag, pat[0]);
        $display("address done");
        for (i = 0; i < 2; i++) begin
            d = i ? 8'($urandom) : 8'h80;
            ldp(frame(d, 1'b1));
            pulse(5'b01000);
            tk(4);
            wd <= ~d;
            pulse(5'b00001);
            ev;
            chk("data", sb, d);
            chk("full", st.buffer_full_flag, 1);
            chk("clash", st.write_clash_flag, 1);
            clr(3'b010);
            pulse(5'b00011);
            tk(3);
            chk("full", st.buffer_full_flag, 0);
            av <= i[0];
            pulse(5'b00100);
            pulse(5'b00001);
            ev;
            chk("go", go, 0);
            chk("clash", st.write_clash_flag, 1);
            clr(3'b010);
            $display("byte %0d done", i);
        end
        pulse(5'b00010);
        pulse(5'b00001);
        ev;
        chk("stopseen", st.stop_seen, 1);
        chk("clash", st.write_clash_flag, 1);
        clr(3'b010);
        en <= 1'b0;
        tk(3);
        en <= 1'b1;
        chk("stopseen", st.stop_seen, 0);
        $display("stop done");
        // rival pulls data on a released bit
        pulse(5'b10000);
        ev;
        ldp(9'h1ff);
        wd <= 8'hff;
        pulse(5'b00001);
        for (k = 0; scl_w !== 1'b1 && k < 900; k++)
            tk(1);
        rival <= 1'b1;
        tk(12);
        chk("collision", st.collision_flag, 1);
        chk("full", st.buffer_full_flag, 0);
        chk("go", go, 0);
        rival <= 1'b0;
        ev;
        clr(3'b001);
        $display("collision done");
        // start while data line already low
        rival <= 1'b1;
        pulse(5'b10000);
        tk(10);
        chk("collision", st.collision_flag, 1);
        chk("go", go, 0);
        rival <= 1'b0;
        clr(3'b101);
        $display("start clash done");
        test_done;
    end
    // watchdog well past the longest run
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        n_mismatch++;
        test_done;
    end
endmodule
`default_nettype wire

// ### sim/tms_master_assertions.sv
// checks on the master ports
`timescale 1ns/1ps
`default_nettype none
module tms_master_assertions
    import tms_pkg::*;
(
    input wire logic              ref_clk_i,
    input wire logic              reset_i,
    input wire logic              enable_i,
    input wire logic              buf_wr_i,
    input wire logic              scl_o,
    input wire logic              sda_o,
    input wire logic              scl_oe_o,
    input wire logic              sda_oe_o,
    input wire tms_go_t           go_o,
    input wire tms_stat_t         stat_o,
    input wire logic [DATA_W-1:0] shift_buffer_reg_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // port fully released
    sequence bus_idle;
        go_o == '0 && !scl_oe_o && !sda_oe_o && !stat_o.buffer_full_flag;
    endsequence
    sequence clash_soon;
        ##[1:3] stat_o.write_clash_flag;
    endsequence
    lines_low_a: assert property (!scl_o && !sda_o)
        else $error("bus line driven high");
    rx_clash_a: assert property (go_o.receive_go && buf_wr_i |-> clash_soon)
        else $error("rx write not flagged");
    late_clash_a: assert property ((go_o.ack_sequence_go || go_o.stop_go) && buf_wr_i |-> clash_soon)
        else $error("ack/stop write not flagged");
    buf_keep_a: assert property ((go_o.ack_sequence_go || go_o.stop_go) && buf_wr_i |=> $stable(shift_buffer_reg_o))
        else $error("refused write landed");
    ack_pull_a: assert property ($rose(go_o.ack_sequence_go) |-> ##[0:2] scl_oe_o)
        else $error("ack clock not pulled");
    ack_end_a: assert property (enable_i && $fell(go_o.ack_sequence_go) && !stat_o.collision_flag |-> ##[0:2] scl_oe_o)
        else $error("ack end clock released");
    stop_pull_a: assert property ($rose(go_o.stop_go) |-> ##[0:2] sda_oe_o)
        else $error("stop data not pulled");
    stop_end_a: assert property (enable_i && $fell(go_o.stop_go) && !stat_o.collision_flag |-> ##[0:2] (stat_o.serial_event_flag && stat_o.stop_seen))
        else $error("stop end unflagged");
    collide_a: assert property ($rose(stat_o.collision_flag) |-> ##[0:2] bus_idle)
        else $error("busy after collision");
    reset_clr_a: assert property (disable iff (1'b0) reset_i || !enable_i |-> ##2 !stat_o.start_seen && !stat_o.stop_seen && go_o == '0)
        else $error("reset left state");
endmodule
bind tms_master tms_master_assertions chk_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .enable_i(enable_i), .buf_wr_i(buf_wr_i), .scl_o(scl_o), .sda_o(sda_o),
    .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .go_o(go_o), .stat_o(stat_o),
    .shift_buffer_reg_o(shift_buffer_reg_o));
`default_nettype wire

// ### sim/tms_slave.sv
// bus slave model: acks, shifts data msb first
`timescale 1ns/1ps
`default_nettype none
module tms_slave (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic       scl_i,
    input  wire logic       ld_i,
    input  wire logic [8:0] pat_i,
    output logic            pull_o
);
    logic [8:0] sr;
    logic       scl_q;
    // next bit after each clock fall; never stretches
    always_ff @(posedge ref_clk_i) begin
        scl_q <= scl_i;
        if (reset_i)
            sr <= '1;
        else if (ld_i)
            sr <= pat_i;
        else if (scl_q && !scl_i)
            sr <= {sr[7:0], 1'b1};
    end
    assign pull_o = ~sr[8]; // a one releases the line to its pull-up
endmodule
`default_nettype wire

// ### src/tms_fifo.sv
// valid/ready fifo for received bytes
`timescale 1ns/1ps
`default_nettype none
module tms_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage, written on accepted push
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // pointers and fill level
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ### src/tms_master.sv
// two-wire bus master sequencer
// Overview of operation
// RULE1 - buffer write while a byte shifts in sets clash flag, write discarded
// RULE2 - read: send eight address bits with direction set, sample ack into flag
// RULE3 - event flag rises at end of ninth clock after address byte
// RULE4 - receive-go clocks a byte; event and buffer-full set after eighth fall
// RULE5 - software clears event, reads byte, acks, ends with nack or stop
// RULE6 - ack-go pulls clock low at once and drives stored ack value
// RULE7 - software picks ack value bit before starting the ack sequence
// RULE8 - ack: wait period, release clock, after high seen wait, drive low
// RULE9 - ack completion clears ack-go, stops rate counter, returns idle
// RULE10 - buffer write during acknowledge sets clash flag, write discarded
// RULE11 - stop: data low, reload count, release clock, release data later
// RULE12 - data high with clock high sets stop-seen; period later event, clear go
// RULE13 - buffer write during stop sets clash flag, write discarded
// RULE14 - reset or disable ends transfer, clears start-seen and stop-seen
// RULE15 - bus busy elsewhere: raise event on detected stop condition
// RULE16 - released data read low with clock high: collision flag, go idle
// RULE17 - collision in byte: stop shifting, clear buffer-full, release lines
// RULE18 - collision in start/stop/ack: abort, release lines, clear go bits
// RULE19 - after collision keep watching bus, event on stop condition
// RULE20 - after collision a buffer write restarts from the first bit
// RULE21 - either line low at start begin: abort, collision flag, idle
// RULE22 - start: count with data high, clock low collides, early data low
// RULE23 - rate counter reloads twice per bus clock period
// RULE24 - software never programs reload values below three
// RULE25 - lines only pulled low or released, never driven high
`timescale 1ns/1ps
`default_nettype none
module tms_master
    import tms_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              reset_i,
    input  wire logic              enable_i,
    input  wire logic [7:0]        rate_reload_reg_i,
    input  wire tms_go_t           go_set_i,
    input  wire logic              ack_value_bit_i,
    input  wire logic              buf_wr_i,
    input  wire logic [DATA_W-1:0] buf_wdata_i,
    input  wire logic              buf_rd_i,
    input  wire logic              clr_event_i,
    input  wire logic              clr_clash_i,
    input  wire logic              clr_collision_i,
    input  wire logic              scl_i,
    input  wire logic              sda_i,
    output logic                   scl_o,
    output logic                   scl_oe_o,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    output tms_go_t                go_o,
    output tms_stat_t              stat_o,
    output logic [DATA_W-1:0]      shift_buffer_reg_o,
    output logic                   rx_overflow_o
);
    tms_state_t        state;
    tms_go_t           go;
    tms_stat_t         stat;
    logic [7:0]        rate_counter;
    logic              rate_run;
    logic              rate_tick;
    logic [3:0]        bit_cnt;
    logic [DATA_W-1:0] internal_shift_reg;
    logic [DATA_W-1:0] shift_buffer_reg;
    logic              scl_low;
    logic              sda_low;
    logic              scl_q;
    logic              sda_q;
    logic              stop_cond;
    logic              start_cond;
    logic              busy;
    logic              wr_ok;
    logic              coll;
    logic              coll_tx;
    logic              byte_done;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic              run;

    assign run       = enable_i && !reset_i;
    assign rate_tick = rate_run && (rate_counter == RESET_BYTE);
    assign busy      = (state != TMS_IDLE);
    // clash writes never land
    assign wr_ok     = buf_wr_i && !busy; // RULE1 RULE10 RULE13
    assign stop_cond = scl_i && scl_q && sda_i && !sda_q;
    assign start_cond = scl_i && scl_q && !sda_i && sda_q;
    // released data seen low under high clock; the ack slot is the slave's
    assign coll_tx = !sda_low && !sda_i && scl_i // RULE16
                   && ((state == TMS_TX_HIGH && bit_cnt != BITS_BYTE) || state == TMS_AK_HIGH);
    assign coll = coll_tx
               || ((state == TMS_ST_HOLD) && sda_i && !scl_i) // RULE22
               || ((state == TMS_SP_DONE) && !sda_i && scl_i);
    // receive stalls while the fifo is full
    assign byte_done = (state == TMS_RX_HIGH) && rate_tick
                    && (bit_cnt == BITS_BYTE - 4'h1) && fifo_in_ready;

    // previous bus levels
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // rate counter, reloads each half period
    always_ff @(posedge ref_clk_i) begin
        if (!run || !rate_run) begin
            rate_counter <= rate_reload_reg_i; // RULE9
        end else if (rate_tick) begin
            rate_counter <= rate_reload_reg_i; // RULE23
        end else begin
            rate_counter <= rate_counter - 8'h01;
        end
    end

    // sequencer
    always_ff @(posedge ref_clk_i) begin
        if (!run) begin
            state              <= TMS_IDLE; // RULE14
            rate_run           <= 1'b0;
            scl_low            <= 1'b0;
            sda_low            <= 1'b0;
            bit_cnt            <= BIT_ZERO;
            internal_shift_reg <= RESET_BYTE;
        end else if (coll) begin
            state    <= TMS_IDLE; // RULE17 RULE18
            rate_run <= 1'b0;
            scl_low  <= 1'b0; // RULE25
            sda_low  <= 1'b0;
            bit_cnt  <= BIT_ZERO; // RULE20
        end else begin
            case (state)
                TMS_IDLE: begin
                    rate_run <= 1'b0;
                    bit_cnt  <= BIT_ZERO; // RULE20
                    if (go_set_i.start_go) begin
                        state <= TMS_ST_CHECK;
                    end else if (wr_ok) begin
                        internal_shift_reg <= buf_wdata_i; // RULE2
                        scl_low  <= 1'b1;
                        rate_run <= 1'b1;
                        state    <= TMS_TX_LOW;
                    end else if (go_set_i.receive_go) begin
                        sda_low  <= 1'b0;
                        rate_run <= 1'b1;
                        state    <= TMS_RX_LOW;
                    end else if (go_set_i.ack_sequence_go) begin
                        scl_low  <= 1'b1; // RULE6
                        sda_low  <= !ack_value_bit_i;
                        rate_run <= 1'b1;
                        state    <= TMS_AK_LOW;
                    end else if (go_set_i.stop_go) begin
                        scl_low <= 1'b1;
                        sda_low <= 1'b1; // RULE11
                        state   <= TMS_SP_LOW;
                    end
                end
                TMS_ST_CHECK: begin
                    if (!sda_i || !scl_i) begin
                        state <= TMS_IDLE; // RULE21
                    end else begin
                        rate_run <= 1'b1; // RULE22
                        state    <= TMS_ST_HOLD;
                    end
                end
                TMS_ST_HOLD: begin
                    if (!sda_i || rate_tick) begin
                        sda_low  <= 1'b1; // RULE22
                        rate_run <= 1'b0;
                        state    <= TMS_ST_LOW;
                    end
                end
                TMS_ST_LOW: begin
                    rate_run <= 1'b1;
                    if (rate_tick) begin
                        scl_low  <= 1'b1; // RULE22
                        rate_run <= 1'b0;
                        state    <= TMS_IDLE;
                    end
                end
                TMS_TX_LOW: begin
                    // data moves with clock low
                    if (bit_cnt == BITS_BYTE) begin
                        sda_low <= 1'b0;
                    end else begin
                        sda_low <= !internal_shift_reg[DATA_W-1];
                    end
                    if (rate_tick) begin
                        scl_low <= 1'b0;
                        state   <= TMS_TX_HIGH;
                    end
                end
                TMS_TX_HIGH: begin
                    if (!scl_i) begin
                        rate_run <= 1'b0; // stretched clock reloads the count
                    end else begin
                        rate_run <= 1'b1;
                    end
                    if (rate_tick) begin
                        scl_low <= 1'b1;
                        if (bit_cnt == BITS_ADDR - 4'h1) begin
                            rate_run <= 1'b0; // RULE3
                            state    <= TMS_IDLE;
                        end else begin
                            internal_shift_reg <= {internal_shift_reg[DATA_W-2:0], 1'b0};
                            bit_cnt <= bit_cnt + 4'h1;
                            state   <= TMS_TX_LOW;
                        end
                    end
                end
                TMS_RX_LOW: begin
                    if (rate_tick) begin
                        scl_low <= 1'b0;
                        state   <= TMS_RX_HIGH;
                    end
                end
                TMS_RX_HIGH: begin
                    rate_run <= scl_i;
                    if (rate_tick && scl_i) begin
                        internal_shift_reg <= {internal_shift_reg[DATA_W-2:0], sda_i};
                    end
                    if (rate_tick && (bit_cnt != BITS_BYTE - 4'h1)) begin
                        scl_low <= 1'b1;
                        bit_cnt <= bit_cnt + 4'h1;
                        state   <= TMS_RX_LOW;
                    end else if (byte_done) begin
                        scl_low  <= 1'b1; // RULE4
                        rate_run <= 1'b0;
                        state    <= TMS_IDLE;
                    end
                end
                TMS_AK_LOW: begin
                    if (rate_tick) begin
                        scl_low <= 1'b0; // RULE8
                        state   <= TMS_AK_HIGH;
                    end
                end
                TMS_AK_HIGH: begin
                    rate_run <= scl_i; // RULE8
                    if (rate_tick && scl_i) begin
                        scl_low  <= 1'b1;
                        rate_run <= 1'b0; // RULE9
                        state    <= TMS_IDLE;
                    end
                end
                TMS_SP_LOW: begin
                    rate_run <= !sda_i; // RULE11
                    if (rate_tick) begin
                        scl_low <= 1'b0;
                        state   <= TMS_SP_SCL;
                    end
                end
                TMS_SP_SCL: begin
                    rate_run <= scl_i;
                    if (rate_tick && scl_i) begin
                        sda_low <= 1'b0; // RULE11
                        state   <= TMS_SP_SDA;
                    end
                end
                TMS_SP_SDA: begin
                    if (sda_i && scl_i) begin
                        state <= TMS_SP_DONE;
                    end
                end
                TMS_SP_DONE: begin
                    if (rate_tick) begin
                        rate_run <= 1'b0; // RULE12
                        state    <= TMS_IDLE;
                    end
                end
                default: begin
                    state <= TMS_IDLE;
                end
            endcase
        end
    end

    // go bits: set by software, cleared by hardware
    always_ff @(posedge ref_clk_i) begin
        if (!run) begin
            go <= '0;
        end else if (coll) begin
            go <= '0; // RULE18
        end else begin
            if (go_set_i.start_go && state == TMS_IDLE) go.start_go <= 1'b1;
            else if (state == TMS_ST_LOW && rate_tick) go.start_go <= 1'b0;
            else if (state == TMS_ST_CHECK && (!sda_i || !scl_i)) go.start_go <= 1'b0;
            if (go_set_i.receive_go && state == TMS_IDLE) go.receive_go <= 1'b1;
            else if (byte_done) go.receive_go <= 1'b0;
            if (go_set_i.ack_sequence_go && state == TMS_IDLE) go.ack_sequence_go <= 1'b1;
            else if (state == TMS_AK_HIGH && rate_tick && scl_i) go.ack_sequence_go <= 1'b0; // RULE9
            if (go_set_i.stop_go && state == TMS_IDLE) go.stop_go <= 1'b1;
            else if (state == TMS_SP_DONE && rate_tick) go.stop_go <= 1'b0; // RULE12
        end
    end

    // sticky status flags; hardware set wins over a same-cycle clear
    always_ff @(posedge ref_clk_i) begin
        if (!run) begin
            stat <= '0; // RULE14
        end else begin
            if ((state == TMS_TX_HIGH && rate_tick && bit_cnt == BITS_ADDR - 4'h1)
                || byte_done
                || (state == TMS_AK_HIGH && rate_tick && scl_i)
                || (state == TMS_ST_LOW && rate_tick)
                || (state == TMS_SP_DONE && rate_tick)
                || (stop_cond && state == TMS_IDLE)) begin
                stat.serial_event_flag <= 1'b1; // RULE3 RULE12 RULE15 RULE19
            end else if (clr_event_i) begin
                stat.serial_event_flag <= 1'b0;
            end
            if (wr_ok || (fifo_out_valid && (buf_rd_i || !stat.buffer_full_flag))) begin
                stat.buffer_full_flag <= 1'b1; // RULE4
            end else if (coll_tx || buf_rd_i) begin
                stat.buffer_full_flag <= 1'b0; // RULE17
            end else if (state == TMS_TX_LOW && bit_cnt == BITS_BYTE) begin
                stat.buffer_full_flag <= 1'b0;
            end
            if (buf_wr_i && busy) begin
                stat.write_clash_flag <= 1'b1; // RULE1 RULE10 RULE13
            end else if (clr_clash_i) begin
                stat.write_clash_flag <= 1'b0;
            end
            if (coll || (state == TMS_ST_CHECK && (!sda_i || !scl_i))) begin
                stat.collision_flag <= 1'b1; // RULE16 RULE21
            end else if (clr_collision_i) begin
                stat.collision_flag <= 1'b0;
            end
            if (state == TMS_TX_HIGH && rate_tick && bit_cnt == BITS_ADDR - 4'h1) begin
                stat.ack_received_flag <= sda_i; // RULE2
            end
            if (start_cond) begin
                stat.start_seen <= 1'b1;
                stat.stop_seen  <= 1'b0;
            end else if (stop_cond) begin
                stat.start_seen <= 1'b0;
                stat.stop_seen  <= 1'b1; // RULE12
            end
        end
    end

    // overflow: byte lands on an unread one
    always_ff @(posedge ref_clk_i) begin
        if (!run) begin
            rx_overflow_o <= 1'b0;
        end else if (byte_done && stat.buffer_full_flag) begin
            rx_overflow_o <= 1'b1;
        end
    end

    // received bytes queue in the fifo
    tms_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk_i   (ref_clk_i),
        .reset_i     (!run),
        .in_data_i   ({internal_shift_reg[DATA_W-2:0], sda_i}),
        .in_valid_i  (byte_done),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (buf_rd_i || !stat.buffer_full_flag)
    );

    // buffer: fifo head or accepted write
    always_ff @(posedge ref_clk_i) begin
        if (!run) begin
            shift_buffer_reg <= RESET_BYTE;
        end else if (wr_ok) begin
            shift_buffer_reg <= buf_wdata_i;
        end else if (fifo_out_valid && (buf_rd_i || !stat.buffer_full_flag)) begin
            shift_buffer_reg <= fifo_out_data;
        end
    end

    // registered outputs; lines only pulled low
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            scl_o              <= 1'b0;
            sda_o              <= 1'b0;
            scl_oe_o           <= 1'b0;
            sda_oe_o           <= 1'b0;
            go_o               <= '0;
            stat_o             <= '0;
            shift_buffer_reg_o <= RESET_BYTE;
        end else begin
            scl_o              <= 1'b0; // RULE25
            sda_o              <= 1'b0; // RULE25
            scl_oe_o           <= scl_low && run;
            sda_oe_o           <= sda_low && run;
            go_o               <= go;
            stat_o             <= stat;
            shift_buffer_reg_o <= shift_buffer_reg;
        end
    end
endmodule
`default_nettype wire

// ### src/tms_pkg.sv
// shared constants and types for the master
package tms_pkg;
    localparam int         DATA_W      = 8;
    localparam int         FIFO_DEPTH  = 4;
    localparam logic [3:0] BITS_BYTE   = 4'h8;
    localparam logic [3:0] BITS_ADDR   = 4'h9;
    localparam logic [7:0] RELOAD_MIN  = 8'h03;
    localparam logic [7:0] RESET_BYTE  = 8'h00;
    localparam logic [3:0] BIT_ZERO    = 4'h0;

    typedef enum logic [3:0] {
        TMS_IDLE     = 4'b0000,
        TMS_ST_CHECK = 4'b0001,
        TMS_ST_HOLD  = 4'b0010,
        TMS_ST_LOW   = 4'b0011,
        TMS_TX_LOW   = 4'b0100,
        TMS_TX_HIGH  = 4'b0101,
        TMS_RX_LOW   = 4'b0110,
        TMS_RX_HIGH  = 4'b0111,
        TMS_AK_LOW   = 4'b1000,
        TMS_AK_HIGH  = 4'b1001,
        TMS_SP_LOW   = 4'b1010,
        TMS_SP_SCL   = 4'b1011,
        TMS_SP_SDA   = 4'b1100,
        TMS_SP_DONE  = 4'b1101
    } tms_state_t;

    // go bits from software
    typedef struct packed {
        logic start_go;
        logic receive_go;
        logic ack_sequence_go;
        logic stop_go;
    } tms_go_t;

    // sticky status shown to software
    typedef struct packed {
        logic serial_event_flag;
        logic buffer_full_flag;
        logic write_clash_flag;
        logic collision_flag;
        logic ack_received_flag;
        logic start_seen;
        logic stop_seen;
    } tms_stat_t;
endpackage
